// File: src/cfg_msg_defines.svh
// Token values, space selectors and byte counts of the configuration message port.
// Assumes inclusion by bare name from the message port, the one file that includes it.
//
// Function
// - A write whose return identifier ends in 0xFF is performed without reply.
// - Multi-byte fields travel most significant byte first, both directions.
// - Status resource identifier is register number shifted left 8, ORed with 0x0B.
// - Tile space answers at tile identifier followed by low half 0xC20C.
// - Node space answers at node identifier followed by low half 0xC30C.
// - Peripheral space answers at node identifier, peripheral byte, low byte 0x02.
// - Write reply: tokens 3 and 1 on success, tokens 4 and 1 on failure.
// - Tile or node read reply: token 3, data word, token 1; else 4, 1.
// - Peripheral read reply: token 3, data, token 1; else tokens 4, 1.
`ifndef CFG_MSG_DEFINES_SVH
`define CFG_MSG_DEFINES_SVH

`define TOK_WRITE 8'hC0
`define TOK_READ 8'hC1
`define TOK_END 8'h01
`define TOK_ACK 8'h03
`define TOK_NAK 8'h04

`define DEST_TILE_LOW 16'hC20C
`define DEST_NODE_LOW 16'hC30C
`define DEST_PERIPH_LOW 8'h02
`define NOREPLY_LOW 8'hFF
`define PS_RES_TYPE 8'h0B

`define SEL_TILE 3'h0
`define SEL_NODE 3'h1
`define SEL_PERIPH0 3'h2

`define RET_LAST 3'h2
`define REG_LAST_WIDE 3'h1
`define REG_LAST_PERIPH 3'h0
`define DATA_LAST 3'h3
`define DATA_LAST_NARROW 3'h1
`define READ_BYTES 3'h4

`endif

// File: src/cfg_msg_pkg.sv
// Types shared by the configuration message port, its channel-end model and its bench.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none

package cfg_msg_pkg;

    // One token of the interconnect stream: control flag plus byte.
    typedef struct packed {
        logic ctrl;
        logic [7:0] data;
    } tok_s;

    typedef enum logic [2:0] {
        S_IDLE = 3'b000,
        S_HDR = 3'b001,
        S_REG = 3'b011,
        S_DATA = 3'b010,
        S_TAIL = 3'b110,
        S_ACC = 3'b111,
        S_REPLY = 3'b101,
        S_DRAIN = 3'b100
    } port_state_e;

    typedef struct packed {
        port_state_e st;
        logic [2:0] cnt;
        logic write;
        logic bad;
        logic ok;
        logic [2:0] sel;
        logic [23:0] ret;
        logic [15:0] regn;
        logic [31:0] wdata;
        logic [31:0] rdata;
        logic [2:0] sent;
        tok_s tx_tok;
        logic [15:0] ps_id;
    } port_state_s;

endpackage : cfg_msg_pkg

`default_nettype wire

// File: src/cfg_reg_mem.sv
// Register store of the three configuration spaces, one word per register.
// Assumes one writer and one reader on the same clock; read data are registered.
`default_nettype none

module cfg_reg_mem #(
    parameter int AW = 8,
    parameter int DW = 32
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Write port
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [DW-1:0] wdata,
    // Read port
    input wire logic re,
    input wire logic [AW-1:0] raddr,
    output logic [DW-1:0] rdata_q
);

    logic [DW-1:0] mem_q [2**AW];

    initial begin
        if (AW < 1 || AW > 12 || DW < 1) begin
            $error("cfg_reg_mem: unsupported geometry");
        end
    end

    // Contents clear at reset so every read has a defined answer.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < 2**AW; i++) begin
                mem_q[i] <= '0;
            end
            rdata_q <= '0;
        end else begin
            if (we) begin
                mem_q[waddr] <= wdata;
            end
            if (re) begin
                rdata_q <= mem_q[raddr];
            end
        end
    end

endmodule : cfg_reg_mem

`default_nettype wire

// File: src/cfg_msg_port.sv
// Message port that decodes token-framed register requests and returns replies.
// Assumes the interconnect delivers tokens on clk with the destination of the
// channel-end beside the opening token, and accepts replies with valid/ready.
`include "cfg_msg_defines.svh"
`default_nettype none

module cfg_msg_port
    import cfg_msg_pkg::*;
#(
    parameter int REG_AW = 5,
    parameter int NUM_PERIPH = 4
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Own identity
    input wire logic [15:0] tile_id,
    input wire logic [15:0] node_id,
    // Request stream
    input wire logic rx_valid,
    output logic rx_ready,
    input wire tok_s rx_tok,
    input wire logic [31:0] rx_dest,
    // Reply stream
    output logic tx_valid,
    input wire logic tx_ready,
    output tok_s tx_tok,
    output logic [23:0] tx_dest,
    // Status resource identifier translation
    input wire logic [7:0] ps_reg_num,
    output logic [15:0] ps_res_id
);

    localparam int MEM_AW = 3 + REG_AW;

    initial begin
        if (REG_AW < 1 || REG_AW > 8 || NUM_PERIPH < 1 || NUM_PERIPH > 6) begin
            $error("cfg_msg_port: unsupported parameters");
        end
    end

    // ******************************************************************
    // Decoding helpers
    // ******************************************************************

    // Returns {hit, selector} for a channel-end destination.
    function automatic logic [3:0] dest_decode(input logic [31:0] dest,
                                               input logic [15:0] tid,
                                               input logic [15:0] nid);
        logic [3:0] r;
        r = 4'h0;
        if (dest[31:16] == tid && dest[15:0] == `DEST_TILE_LOW) begin
            r = {1'b1, `SEL_TILE};
        end else if (dest[31:16] == nid && dest[15:0] == `DEST_NODE_LOW) begin
            r = {1'b1, `SEL_NODE};
        end else if (dest[31:16] == nid && dest[7:0] == `DEST_PERIPH_LOW
                     && dest[15:8] < 8'(NUM_PERIPH)) begin
            r = {1'b1, 3'(`SEL_PERIPH0 + dest[10:8])};
        end
        return r;
    endfunction : dest_decode

    function automatic logic [15:0] ps_resource_id(input logic [7:0] num);
        return {num, `PS_RES_TYPE};
    endfunction : ps_resource_id

    // ******************************************************************
    // State
    // ******************************************************************

    port_state_s q, d;
    logic rx_fire;
    logic tx_fire;
    logic mem_we;
    logic mem_re;
    logic [31:0] mem_rdata;
    logic [MEM_AW-1:0] mem_addr;

    assign rx_fire = rx_valid && rx_ready;
    assign tx_fire = tx_valid && tx_ready;
    assign mem_addr = {q.sel, q.regn[REG_AW-1:0]};

    always_comb begin
        logic fin;
        logic bad_now;
        logic periph;
        logic [3:0] dec;
        fin = 1'b0;
        bad_now = q.bad;
        periph = q.sel >= `SEL_PERIPH0;
        dec = dest_decode(rx_dest, tile_id, node_id);
        d = q;
        mem_we = 1'b0;
        mem_re = 1'b0;
        rx_ready = 1'b0;
        d.ps_id = ps_resource_id(ps_reg_num);
        case (q.st)
            S_IDLE: begin
                rx_ready = 1'b1;
                if (rx_fire && !(rx_tok.ctrl && rx_tok.data == `TOK_END)) begin
                    d.st = S_HDR;
                    d.cnt = 3'h0;
                    d.write = rx_tok.data == `TOK_WRITE;
                    d.bad = !rx_tok.ctrl || !dec[3]
                        || (rx_tok.data != `TOK_WRITE && rx_tok.data != `TOK_READ);
                    d.sel = dec[2:0];
                    d.ret = 24'h00_0000;
                    d.regn = 16'h0000;
                    d.wdata = 32'h0000_0000;
                end
            end
            S_HDR: begin
                rx_ready = 1'b1;
                if (rx_fire && rx_tok.ctrl) begin
                    // An end token before the whole return identifier closes without reply; other control tokens drain to a failure reply.
                    d.st = (rx_tok.data == `TOK_END) ? S_IDLE : S_DRAIN;
                end else if (rx_fire) begin
                    d.ret = {q.ret[15:0], rx_tok.data};
                    d.cnt = q.cnt + 3'h1;
                    if (q.cnt == `RET_LAST) begin
                        d.st = S_REG;
                        d.cnt = 3'h0;
                    end
                end
            end
            S_REG: begin
                rx_ready = 1'b1;
                if (rx_fire && rx_tok.ctrl) begin
                    bad_now = 1'b1;
                    fin = rx_tok.data == `TOK_END;
                    d.st = S_DRAIN;
                end else if (rx_fire) begin
                    d.regn = {q.regn[7:0], rx_tok.data};
                    d.cnt = q.cnt + 3'h1;
                    if (q.cnt == (periph ? `REG_LAST_PERIPH : `REG_LAST_WIDE)) begin
                        d.st = q.write ? S_DATA : S_TAIL;
                        d.cnt = 3'h0;
                    end
                end
            end
            S_DATA: begin
                rx_ready = 1'b1;
                if (rx_fire && rx_tok.ctrl) begin
                    // A peripheral may close after a single data byte.
                    bad_now = q.bad || !(periph && q.cnt == `DATA_LAST_NARROW);
                    fin = rx_tok.data == `TOK_END;
                    d.st = S_DRAIN;
                end else if (rx_fire) begin
                    d.wdata = {q.wdata[23:0], rx_tok.data};
                    d.cnt = q.cnt + 3'h1;
                    if (q.cnt == `DATA_LAST) begin
                        d.st = S_TAIL;
                    end
                end
            end
            S_TAIL: begin
                rx_ready = 1'b1;
                if (rx_fire) begin
                    bad_now = q.bad || !rx_tok.ctrl || rx_tok.data != `TOK_END;
                    fin = rx_tok.ctrl && rx_tok.data == `TOK_END;
                    d.st = S_DRAIN;
                end
            end
            S_DRAIN: begin
                rx_ready = 1'b1;
                bad_now = 1'b1;
                fin = rx_fire && rx_tok.ctrl && rx_tok.data == `TOK_END;
            end
            S_ACC: begin
                d.rdata = mem_rdata;
                d.st = S_REPLY;
            end
            S_REPLY: begin
                if (tx_fire) begin
                    if (q.tx_tok.ctrl && q.tx_tok.data == `TOK_END) begin
                        d.st = S_IDLE;
                    end else if (q.ok && !q.write && q.sent < `READ_BYTES) begin
                        d.tx_tok = '{ctrl: 1'b0, data: q.rdata[31:24]};
                        d.rdata = {q.rdata[23:0], 8'h00};
                        d.sent = q.sent + 3'h1;
                    end else begin
                        d.tx_tok = '{ctrl: 1'b1, data: `TOK_END};
                    end
                end
            end
            default: begin
                d.st = S_IDLE;
            end
        endcase
        if (fin) begin
            d.bad = bad_now;
            d.ok = !bad_now && q.regn[15:REG_AW] == '0;
            d.sent = 3'h0;
            d.tx_tok = '{ctrl: 1'b1, data: d.ok ? `TOK_ACK : `TOK_NAK};
            mem_we = d.ok && q.write;
            mem_re = d.ok && !q.write;
            if (q.write && q.ret[7:0] == `NOREPLY_LOW) begin
                d.st = S_IDLE;
            end else begin
                d.st = mem_re ? S_ACC : S_REPLY;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '{st: S_IDLE, tx_tok: '{ctrl: 1'b0, data: 8'h00}, default: '0};
        end else begin
            q <= d;
        end
    end

    assign tx_valid = q.st == S_REPLY;
    assign tx_tok = q.tx_tok;
    assign tx_dest = q.ret;
    assign ps_res_id = q.ps_id;

    cfg_reg_mem #(
        .AW(MEM_AW),
        .DW(32)
    ) u_mem (
        .clk(clk),
        .rst_n(rst_n),
        .we(mem_we),
        .waddr(mem_addr),
        .wdata(q.wdata),
        .re(mem_re),
        .raddr(mem_addr),
        .rdata_q(mem_rdata)
    );

    // ******************************************************************
    // Checks
    // ******************************************************************

    chk_reply_dest: assert property (@(posedge clk) disable iff (!rst_n)
        tx_valid && !$past(tx_valid) |-> tx_dest == $past(q.ret, 2) || tx_dest == $past(q.ret))
        else $error("reply destination differs from return identifier");
    chk_no_reply: assert property (@(posedge clk) disable iff (!rst_n)
        mem_we && q.ret[7:0] == `NOREPLY_LOW |=> !tx_valid && q.st == S_IDLE)
        else $error("reply sent for a write that suppressed it");
    chk_msb_first: assert property (@(posedge clk) disable iff (!rst_n)
        tx_valid && !tx_tok.ctrl && $past(tx_fire) |-> tx_tok.data == $past(q.rdata[31:24]))
        else $error("read data not sent most significant byte first");
    chk_ps_ident: assert property (@(posedge clk) disable iff (!rst_n)
        $past(rst_n) |-> ps_res_id[7:0] == 8'h0B && ps_res_id[15:8] == $past(ps_reg_num))
        else $error("status resource identifier wrong");
    chk_tile_decode: assert property (@(posedge clk) disable iff (!rst_n)
        q.st == S_IDLE && rx_fire && rx_tok.ctrl && rx_tok.data == `TOK_WRITE
        && rx_dest == {tile_id, `DEST_TILE_LOW} |=> q.sel == `SEL_TILE && !q.bad)
        else $error("tile space not selected");
    chk_node_decode: assert property (@(posedge clk) disable iff (!rst_n)
        q.st == S_IDLE && rx_fire && rx_tok.ctrl && rx_tok.data == `TOK_READ
        && rx_dest[15:0] == `DEST_NODE_LOW && rx_dest[31:16] == node_id
        && node_id != tile_id |=> q.sel == `SEL_NODE && !q.bad)
        else $error("node space not selected");
    chk_periph_decode: assert property (@(posedge clk) disable iff (!rst_n)
        q.st == S_IDLE && rx_fire && rx_tok.ctrl && rx_tok.data == `TOK_READ
        && rx_dest == {node_id, 8'h00, `DEST_PERIPH_LOW} |=> q.sel == `SEL_PERIPH0)
        else $error("peripheral space not selected");
    chk_nak_close: assert property (@(posedge clk) disable iff (!rst_n)
        tx_fire && tx_tok.ctrl && tx_tok.data == `TOK_NAK
        |=> tx_valid && tx_tok.ctrl && tx_tok.data == `TOK_END)
        else $error("failure reply not closed by end token");
    chk_read_reply: assert property (@(posedge clk) disable iff (!rst_n)
        tx_fire && tx_tok.data == `TOK_ACK && tx_tok.ctrl && !q.write
        |=> tx_valid && !tx_tok.ctrl)
        else $error("read success reply carries no data");
    chk_open_token: assert property (@(posedge clk) disable iff (!rst_n)
        tx_valid && !$past(tx_valid) |-> tx_tok.ctrl
        && (tx_tok.data == `TOK_ACK || tx_tok.data == `TOK_NAK))
        else $error("reply opens with a wrong token");
    chk_bad_nowrite: assert property (@(posedge clk) disable iff (!rst_n)
        mem_we |-> rx_fire && rx_tok.ctrl && rx_tok.data == `TOK_END && !q.bad)
        else $error("store written without a well-formed request");

endmodule : cfg_msg_port

`default_nettype wire

// File: tb/cfg_partner.sv
// Requesting channel-end model: sends request tokens and collects reply tokens.
// Assumes the port's valid/ready handshakes, sampled at the rising edge of clk.
`default_nettype none

module cfg_partner
    import cfg_msg_pkg::*;
(
    // Clock
    input wire logic clk,
    // Request stream
    output logic rx_valid,
    input wire logic rx_ready,
    output tok_s rx_tok,
    output logic [31:0] rx_dest,
    // Reply stream
    input wire logic tx_valid,
    output logic tx_ready,
    input wire tok_s tx_tok,
    input wire logic [23:0] tx_dest
);
    timeunit 1ns;
    timeprecision 1ps;

    tok_s rq[$];
    logic [23:0] last_dest;
    logic slow;
    logic stuck;

    initial begin
        rx_valid = 1'b0;
        rx_tok = '0;
        rx_dest = '0;
        slow = 1'b0;
        stuck = 1'b0;
        last_dest = '0;
    end

    // Each token is held until taken or for at most 100 cycles; idle token lines show the inverse of the last token, the destination only after the last.
    task automatic send(input logic [31:0] dest, input tok_s m[$]);
        int k;
        int w;
        for (k = 0; k < m.size(); k++) begin
            if (slow && k > 0 && $urandom_range(1) == 1) begin
                rx_valid <= 1'b0;
                rx_tok <= ~m[k-1];
                @(posedge clk);
            end
            rx_valid <= 1'b1;
            rx_tok <= m[k];
            rx_dest <= dest;
            w = 0;
            do begin
                @(posedge clk);
                w++;
            end while (!rx_ready && w < 100);
            if (w >= 100) stuck = 1'b1;
        end
        rx_valid <= 1'b0;
        rx_tok <= ~m[m.size()-1];
        rx_dest <= ~dest;
    endtask : send

    always @(posedge clk) begin
        if (tx_valid && tx_ready) begin
            rq.push_back(tx_tok);
            last_dest <= tx_dest;
        end
        tx_ready <= slow ? ($urandom_range(2) != 0) : 1'b1;
    end

endmodule : cfg_partner

`default_nettype wire

// File: tb/tb.sv
// Self-checking bench of the configuration message port with a channel-end model.
// Assumes the port's hand-over timing; the register store is modelled here.
`default_nettype none

module tb
    import cfg_msg_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk;
    logic rst_n;
    logic [15:0] tile_id;
    logic [15:0] node_id;
    logic rx_valid;
    logic rx_ready;
    tok_s rx_tok;
    logic [31:0] rx_dest;
    logic tx_valid;
    logic tx_ready;
    tok_s tx_tok;
    logic [23:0] tx_dest;
    logic [7:0] ps_reg_num;
    logic [15:0] ps_res_id;
    int failures;
    int checks;
    tok_s m[$];
    tok_s e[$];
    logic [31:0] mdl [6][32];
    int i;
    logic [7:0] r;

    cfg_msg_port #(.REG_AW(5), .NUM_PERIPH(4)) dut (.clk(clk), .rst_n(rst_n),
        .tile_id(tile_id), .node_id(node_id), .rx_valid(rx_valid), .rx_ready(rx_ready),
        .rx_tok(rx_tok), .rx_dest(rx_dest), .tx_valid(tx_valid), .tx_ready(tx_ready),
        .tx_tok(tx_tok), .tx_dest(tx_dest), .ps_reg_num(ps_reg_num), .ps_res_id(ps_res_id));

    cfg_partner p (.clk(clk), .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_tok(rx_tok),
        .rx_dest(rx_dest), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_tok(tx_tok),
        .tx_dest(tx_dest));

    always #25 clk = ~clk;

    // ****************************************************************
    // Helpers
    // ****************************************************************
    task automatic stop_test();
        $display("checks=%0d failures=%0d", checks, failures);
        if (failures == 0 && checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : stop_test

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // Appends n bytes of v, most significant first, to the request or expected queue.
    task automatic put(input bit to_e, input logic c, input logic [31:0] v, input int n);
        int k;
        for (k = n - 1; k >= 0; k--) begin
            if (to_e) e.push_back({c, v[8*k +: 8]});
            else m.push_back({c, v[8*k +: 8]});
        end
    endtask : put

    task automatic run(input logic [31:0] dest, input logic [23:0] ret);
        int k;
        @(posedge clk);
        p.rq.delete();
        p.send(dest, m);
        for (k = 0; k < 80 && !(e.size() > 0 && p.rq.size() >= e.size()); k++) @(posedge clk);
        if (e.size() > 0 && k == 80) begin
            failures++;
            stop_test();
        end
        repeat (3) @(posedge clk);
        chk(p.stuck, 1'b0);
        chk(p.rq.size(), e.size());
        for (k = 0; k < e.size() && k < p.rq.size(); k++) chk(p.rq[k], e[k]);
        if (e.size() > 0) chk(p.last_dest, ret);
        m.delete();
        e.delete();
    endtask : run

    task automatic access(input int sp, input bit wr, input logic [15:0] rg,
                          input logic [31:0] d, input bit nar, input logic [23:0] ret);
        logic [31:0] dest;
        bit ok;
        dest = sp == 0 ? {tile_id, 16'hC20C} : sp == 1 ? {node_id, 16'hC30C}
                       : {node_id, 8'(sp - 2), 8'h02};
        ok = rg < 32;
        put(0, 1, wr ? 8'hC0 : 8'hC1, 1);
        put(0, 0, ret, 3);
        put(0, 0, rg, sp < 2 ? 2 : 1);
        if (wr) put(0, 0, d, nar ? 1 : 4);
        put(0, 1, 8'h01, 1);
        if (wr && ok) mdl[sp][rg[4:0]] = nar ? {24'h00_0000, d[7:0]} : d;
        put(1, 1, ok ? 8'h03 : 8'h04, 1);
        if (!wr && ok) put(1, 0, mdl[sp][rg[4:0]], 4);
        put(1, 1, 8'h01, 1);
        if (wr && ret[7:0] == 8'hFF) e.delete();
        run(dest, ret);
    endtask : access

    task automatic bad(input logic [31:0] dest, input logic [7:0] op, input int nr, input int nd);
        put(0, 1, op, 1);
        put(0, 0, 24'h12_3456, 3);
        put(0, 0, 16'h0003, nr);
        put(0, 0, 32'hDEAD_BEEF, nd);
        put(0, 1, 8'h01, 1);
        put(1, 1, 8'h04, 1);
        put(1, 1, 8'h01, 1);
        run(dest, 24'h12_3456);
    endtask : bad

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        void'($urandom(32'haf5d));
        clk = 1'b0;
        rst_n = 1'b0;
        tile_id = 16'($urandom);
        node_id = 16'($urandom);
        ps_reg_num = 8'h00;
        failures = 0;
        checks = 0;
        foreach (mdl[a, b]) mdl[a][b] = 32'h0000_0000;
        repeat (2) @(posedge clk);
        chk(tx_valid, 1'b0);
        chk(rx_ready, 1'b1);
        chk(ps_res_id, 16'h0000);
        rst_n <= 1'b1;
        for (i = 0; i < 8; i++) begin
            r = i == 0 ? 8'hFF : 8'($urandom);
            ps_reg_num <= r;
            repeat (2) @(posedge clk);
            chk(ps_res_id, {r, 8'h0B});
        end
        access(0, 1, 16'h0003, 32'hA5A5_1234, 0, 24'h00_0101);
        access(0, 0, 16'h0003, 0, 0, 24'h00_0102);
        access(1, 1, 16'h001F, 32'h8001_7FFE, 0, 24'h00_0203);
        access(1, 0, 16'h001F, 0, 0, 24'h00_0204);
        access(5, 1, 16'h0007, 32'h1122_3344, 0, 24'h00_0305);
        access(5, 1, 16'h0008, 32'hFFFF_FF9C, 1, 24'h00_0306);
        access(5, 0, 16'h0008, 0, 0, 24'h00_0307);
        access(2, 1, 16'h0001, 32'h0BAD_CAFE, 0, 24'hAB_CDFF);
        access(2, 0, 16'h0001, 0, 0, 24'hAB_CDFF);
        access(0, 1, 16'h0020, 32'h5555_5555, 0, 24'h00_0401);
        access(4, 0, 16'h0020, 0, 0, 24'h00_0402);
        bad({tile_id, 16'hC20C}, 8'hC5, 2, 4);
        bad({tile_id, 16'hC40C}, 8'hC0, 2, 4);
        bad({tile_id, 16'hC20C}, 8'hC0, 2, 3);
        bad({tile_id, 16'hC20C}, 8'hC0, 2, 5);
        bad({node_id, 8'h04, 8'h02}, 8'hC0, 1, 4);
        access(0, 0, 16'h0003, 0, 0, 24'h00_0501);
        for (i = 0; i < 60; i++) begin
            p.slow = (i / 15) % 2;
            r = 8'($urandom_range(5));
            access(r, $urandom_range(1), 16'($urandom_range(35)), $urandom,
                   r > 1 && $urandom_range(1) == 1,
                   $urandom_range(3) == 0 ? 24'h34_56FF : 24'($urandom_range(24'hFF_FEFE)));
        end
        p.slow = 1'b0;
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        foreach (mdl[a, b]) mdl[a][b] = 32'h0000_0000;
        access(1, 0, 16'h001F, 0, 0, 24'h00_0601);
        stop_test();
    end

endmodule : tb

`default_nettype wire
